// ### fug_traffic_generator.sv
// Notes on behaviour
// (RQ1) Enter resume mode only after user data ends
// (RQ2) Flow data appears together with flow valid
// (RQ3) After fixed resume cycles, switch to pause
// (RQ4) State changes wait for link ready; FL_WAIT to FL_XON and the return to FL_WAIT on channel drop do not
// (RQ5) Flow message spacing set by build parameter
// (RQ6) Flow valid held high until ready
// (RQ7) Flow word stable; low byte is pause length
// (RQ8) Flow bit seven is the pause flag
// (RQ9) Flow word: seven zeros, flag, length
// (RQ10) Link raises flow ready on acceptance
// (RQ11) Control valid only after its gap
// (RQ12) Block number counts zero up to eight
// (RQ13) Control block rate set by build parameter
// (RQ14) Control word: four zeros, number, payload
// (RQ15) Control valid only with valid word
// (RQ16) Link raises control ready when it can
// (RQ17) Link reports channel up after initialization
// (RQ18) One shared user clock for all handshakes
// (RQ19) High reset restores machines and counters
// (RQ20) Pause messages flagged; resume messages carry length
// (RQ21) Silent while channel down, restart after up
//
// Chosen here: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module fug_traffic_generator
   import fug_pkg::*;
#(
   parameter int unsigned flow_msg_gap_param   = FLOW_GAP_DEF,
   parameter int unsigned ctrl_block_gap_param = CB_GAP_DEF
)
(
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              chan_up_i,
   input  wire logic              tx_busy_i,
   output var  logic              flow_valid_o,
   output var  logic [0:FLOW_W-1] flow_data_o,
   input  wire logic              flow_ready_i,
   output var  logic              cb_valid_o,
   output var  logic [0:CB_W-1]   cb_data_o,
   input  wire logic              cb_ready_i,
   input  wire logic [3:0]        avs_address_i,
   input  wire logic              avs_read_i,
   input  wire logic              avs_write_i,
   input  wire logic [31:0]       avs_writedata_i,
   input  wire logic [3:0]        avs_byteenable_i,
   output var  logic [31:0]       avs_readdata_o,
   output var  logic              avs_waitrequest_o
);
   // Register state
   logic                  flow_en_reg;
   logic                  cb_en_reg;
   logic [7:0]            pause_reg;
   logic                  wait_reg;
   logic [31:0]           rdata_reg;
   logic [CNT_W-1:0]      flow_cnt_reg;
   logic [CNT_W-1:0]      cb_cnt_reg;

   // Flow-control state
   fug_flow_state_t       state_reg;
   fug_flow_state_t       state_next;
   logic [CNT_W-1:0]      dwell_reg;
   logic                  flow_valid_reg;
   logic                  flow_valid_next;
   logic [0:FLOW_W-1]     flow_data_reg;
   logic [0:FLOW_W-1]     flow_data_next;

   // Control-block state
   logic                  cb_run_reg;
   logic                  cb_valid_reg;
   logic                  cb_valid_next;
   logic [3:0]            cb_num_reg;
   logic [3:0]            cb_num_next;
   logic [0:CB_W-1]       cb_data_reg;
   logic [0:CB_W-1]       cb_data_next;

   fug_gap_if flow_gap ();
   fug_gap_if cb_gap ();

   // Gap timers for the two message streams
   fug_gap_timer #(.GAP(flow_msg_gap_param)) u_flow_gap    // RQ5
   (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .gap   (flow_gap.timer)
   );

   fug_gap_timer #(.GAP(ctrl_block_gap_param)) u_cb_gap    // RQ13
   (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .gap   (cb_gap.timer)
   );

   // Bus decode: one wait cycle, then the access completes
   wire bus_req    = avs_read_i | avs_write_i;
   wire bus_done   = bus_req & ~wait_reg;
   wire sel_ctrl   = (avs_address_i == REG_CTRL);
   wire sel_status = (avs_address_i == REG_STATUS);
   wire sel_count  = (avs_address_i == REG_COUNT);
   wire wr_ctrl    = avs_write_i & bus_done & sel_ctrl;

   // Register views
   wire [31:0] ctrl_view   = {16'h0000, pause_reg, 6'h00, cb_en_reg, flow_en_reg};
   wire [31:0] status_view = {24'h000000, cb_num_reg, 1'b0, state_reg, chan_up_i};
   wire [31:0] count_view  = {cb_cnt_reg, flow_cnt_reg};
   wire [31:0] rd_mux      = sel_ctrl   ? ctrl_view :
                             sel_status ? status_view :
                             sel_count  ? count_view : 32'h0000_0000;

   // Bus handshake and read data
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wait_reg  <= 1'b1;
         rdata_reg <= 32'h0000_0000;
      end
      else
      begin
         wait_reg  <= ~(bus_req & wait_reg);
         rdata_reg <= (avs_read_i & wait_reg) ? rd_mux : rdata_reg;
      end
   end

   // Control register writes, byte lanes honoured
   always_ff @(posedge clk_i)
   begin
      if (rst_i)                                               // RQ19
      begin
         flow_en_reg <= FLOW_EN_RST;
         cb_en_reg   <= CB_EN_RST;
         pause_reg   <= PAUSE_RST;
      end
      else if (wr_ctrl)
      begin
         if (avs_byteenable_i[0])
         begin
            flow_en_reg <= avs_writedata_i[CTRL_FLOW_EN];
            cb_en_reg   <= avs_writedata_i[CTRL_CB_EN];
         end
         if (avs_byteenable_i[1])
            pause_reg <= avs_writedata_i[CTRL_PAUSE_LO +: 8];
      end
   end

   // Flow-control handshake and timing terms
   wire fl_hs      = flow_valid_reg & flow_ready_i & chan_up_i; // RQ10 RQ18
   wire dwell_done = (dwell_reg >= XON_DWELL_CYC);
   wire fl_mode    = (state_reg == FL_XON) | (state_reg == FL_XOFF);
   wire fl_enter   = (state_reg == FL_WAIT) & (state_next == FL_XON);
   wire fl_is_xoff = (state_reg == FL_XOFF);

   assign flow_gap.load = fl_enter | fl_hs;
   wire fl_send = chan_up_i & fl_mode & flow_gap.expired & ~flow_valid_reg & ~flow_gap.load;

   // Flow-control next state
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         FL_WAIT:
         begin
            if (chan_up_i & flow_en_reg & ~tx_busy_i)          // RQ1
               state_next = FL_XON;
         end
         FL_XON:
         begin
            if (fl_hs & dwell_done)                            // RQ3 RQ4
               state_next = FL_XOFF;
         end
         FL_XOFF:
         begin
            if (fl_hs)                                         // RQ4
               state_next = FL_WAIT;
         end
         default:
            state_next = FL_WAIT;
      endcase
      if (!chan_up_i)                                          // RQ21
         state_next = FL_WAIT;
   end

   // Flow valid holds until ready; word built with the valid
   assign flow_valid_next = ~chan_up_i ? 1'b0 :               // RQ21
                            fl_hs      ? 1'b0 :               // RQ6
                            fl_send    ? 1'b1 : flow_valid_reg;
   assign flow_data_next  = fl_send ? {7'h00, fl_is_xoff, pause_reg} // RQ8 RQ9 RQ20
                                    : flow_data_reg;          // RQ7

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_reg      <= FL_WAIT;
         flow_valid_reg <= 1'b0;
         flow_data_reg  <= 16'h0000;
      end
      else
      begin
         state_reg      <= state_next;
         flow_valid_reg <= flow_valid_next;                    // RQ2
         flow_data_reg  <= flow_data_next;                     // RQ2
      end
   end

   // Cycles spent in resume mode
   always_ff @(posedge clk_i)
   begin
      if (rst_i || state_reg != FL_XON)
         dwell_reg <= 16'h0000;
      else if (!dwell_done)
         dwell_reg <= dwell_reg + 16'h0001;
   end

   // Control-block handshake and timing terms
   wire cb_active = chan_up_i & cb_en_reg;
   wire cb_hs     = cb_valid_reg & cb_ready_i & cb_active;   // Taken only while up and enabled
   assign cb_gap.load = (cb_active & ~cb_run_reg) | cb_hs;
   wire cb_send   = cb_active & cb_run_reg & cb_gap.expired & ~cb_valid_reg & ~cb_gap.load;

   assign cb_valid_next = ~cb_active ? 1'b0 :                 // RQ21
                          cb_hs      ? 1'b0 :
                          cb_send    ? 1'b1 : cb_valid_reg;   // RQ11
   assign cb_num_next   = ~cb_active ? CB_NUM_RST :
                          ~cb_hs     ? cb_num_reg :
                          (cb_num_reg == CB_NUM_LAST) ? CB_NUM_RST
                                     : cb_num_reg + 4'h1;     // RQ12
   assign cb_data_next  = cb_send ? {4'h0, cb_num_reg, CB_PAYLOAD} // RQ14
                                  : cb_data_reg;              // RQ15

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cb_run_reg   <= 1'b0;
         cb_valid_reg <= 1'b0;
         cb_num_reg   <= CB_NUM_RST;
         cb_data_reg  <= 64'h0000_0000_0000_0000;
      end
      else
      begin
         cb_run_reg   <= cb_active;
         cb_valid_reg <= cb_valid_next;
         cb_num_reg   <= cb_num_next;
         cb_data_reg  <= cb_data_next;
      end
   end

   // Accepted message counters
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         flow_cnt_reg <= 16'h0000;
         cb_cnt_reg   <= 16'h0000;
      end
      else
      begin
         flow_cnt_reg <= flow_cnt_reg + {15'h0000, fl_hs};
         cb_cnt_reg   <= cb_cnt_reg + {15'h0000, cb_hs};
      end
   end

   // Outputs straight from flip-flops
   assign flow_valid_o      = flow_valid_reg;
   assign flow_data_o       = flow_data_reg;
   assign cb_valid_o        = cb_valid_reg;
   assign cb_data_o         = cb_data_reg;
   assign avs_readdata_o    = rdata_reg;
   assign avs_waitrequest_o = wait_reg;

   // Checks on the generator's own behaviour
   default clocking cb_clk @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_fl_pending;
      flow_valid_reg && !flow_ready_i && chan_up_i;
   endsequence

   sequence s_cb_accept;
      cb_valid_reg && cb_ready_i && cb_active;
   endsequence

   property p_fl_hold;
      s_fl_pending |=> flow_valid_reg && $stable(flow_data_reg);
   endproperty
   a_fl_hold: assert property (p_fl_hold)                     // RQ6 RQ7
      else $error("flow message dropped or changed before ready");

   property p_fl_layout;
      flow_valid_reg |-> flow_data_reg[0:6] == 7'h00;
   endproperty
   a_fl_layout: assert property (p_fl_layout)                 // RQ9
      else $error("flow word upper bits not zero");

   // Length is checked as loaded; software may retune it while a word waits
   property p_fl_flag;
      flow_valid_reg |-> (flow_data_reg[7] == (state_reg == FL_XOFF))
                         && (!$rose(flow_valid_reg) || flow_data_reg[8:15] == $past(pause_reg));
   endproperty
   a_fl_flag: assert property (p_fl_flag)                     // RQ8 RQ20
      else $error("flow word flag or length wrong for mode");

   property p_fl_busy;
      state_reg == FL_WAIT && tx_busy_i |=> state_reg == FL_WAIT;
   endproperty
   a_fl_busy: assert property (p_fl_busy)                     // RQ1
      else $error("resume mode entered during user data");

   property p_fl_ready_gate;
      $past(chan_up_i) && $past(state_reg) != FL_WAIT && state_reg != $past(state_reg)
         |-> $past(flow_valid_reg && flow_ready_i);
   endproperty
   a_fl_ready_gate: assert property (p_fl_ready_gate)         // RQ4
      else $error("flow state changed without ready");

   property p_fl_xoff;
      state_reg == FL_XON && fl_hs && dwell_done |=> state_reg == FL_XOFF;
   endproperty
   a_fl_xoff: assert property (p_fl_xoff)                     // RQ3
      else $error("pause mode not entered after resume period");

   property p_fl_gap;
      fl_hs && chan_up_i |=> !flow_valid_reg [*2];
   endproperty
   a_fl_gap: assert property (p_fl_gap)                       // RQ5
      else $error("flow messages closer than gap");

   property p_down;
      !chan_up_i |=> !flow_valid_reg && !cb_valid_reg;
   endproperty
   a_down: assert property (p_down)                           // RQ21
      else $error("traffic while channel down");

   property p_cb_hold;
      cb_valid_reg && !cb_ready_i && cb_active |=> cb_valid_reg && $stable(cb_data_reg);
   endproperty
   a_cb_hold: assert property (p_cb_hold)                     // RQ15
      else $error("control word changed before ready");

   property p_cb_gap;
      s_cb_accept |=> !cb_valid_reg [*2];
   endproperty
   a_cb_gap: assert property (p_cb_gap)                       // RQ11
      else $error("control block sent before gap");

   property p_cb_count;
      s_cb_accept |=> cb_num_reg == (($past(cb_num_reg) == CB_NUM_LAST) ? CB_NUM_RST
                                     : $past(cb_num_reg) + 4'h1);
   endproperty
   a_cb_count: assert property (p_cb_count)                   // RQ12
      else $error("block number did not advance");

   property p_cb_layout;
      cb_valid_reg |-> cb_data_reg[0:3] == 4'h0 && cb_data_reg[4:7] <= CB_NUM_LAST
                       && cb_data_reg[8:CB_W-1] == CB_PAYLOAD;
   endproperty
   a_cb_layout: assert property (p_cb_layout)                 // RQ14
      else $error("control word layout wrong");
endmodule : fug_traffic_generator
`default_nettype wire

// ### fug_pkg.sv
`default_nettype none
package fug_pkg;
   // Lanes and data widths
   localparam int          LANES         = 1;
   localparam int          CB_W          = 64 * LANES;
   localparam int          CB_PAY_W      = 56 * LANES;
   localparam int          FLOW_W        = 16;
   localparam int          CNT_W         = 16;

   // Default gaps between messages, in user clock cycles
   localparam int unsigned FLOW_GAP_DEF  = 100;
   localparam int unsigned CB_GAP_DEF    = 50;

   // Cycles spent in resume mode before a pause request is sent
   localparam logic [CNT_W-1:0] XON_DWELL_CYC = 16'h0100;

   // Control-block numbering
   localparam logic [3:0]  CB_NUM_LAST   = 4'h8;
   localparam logic [3:0]  CB_NUM_RST    = 4'h0;
   localparam logic [CB_PAY_W-1:0] CB_PAYLOAD = 56'h5a_c3_96_3c_a5_69_0f;

   // Register byte offsets
   localparam logic [3:0]  REG_CTRL      = 4'h0;
   localparam logic [3:0]  REG_STATUS    = 4'h4;
   localparam logic [3:0]  REG_COUNT     = 4'h8;

   // Control register fields and reset values
   localparam int          CTRL_FLOW_EN  = 0;
   localparam int          CTRL_CB_EN    = 1;
   localparam int          CTRL_PAUSE_LO = 8;
   localparam logic        FLOW_EN_RST   = 1'b1;
   localparam logic        CB_EN_RST     = 1'b1;
   localparam logic [7:0]  PAUSE_RST     = 8'h0f;

   // Status register fields
   localparam int          STAT_CHAN_UP  = 0;
   localparam int          STAT_STATE_LO = 1;
   localparam int          STAT_NUM_LO   = 4;

   // Flow-control message state machine
   typedef enum logic [1:0]
   {
      FL_WAIT = 2'b00,
      FL_XON  = 2'b01,
      FL_XOFF = 2'b10
   } fug_flow_state_t;
endpackage : fug_pkg
`default_nettype wire

// ### fug_gap_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fug_gap_if;
   logic load;
   logic expired;

   modport timer (input load, output expired);
   modport user  (output load, input expired);
endinterface : fug_gap_if
`default_nettype wire

// ### fug_gap_timer.sv
`timescale 1ns/1ps
`default_nettype none
module fug_gap_timer
   import fug_pkg::*;
#(
   parameter int unsigned GAP = 16
)
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   fug_gap_if.timer  gap
);
   localparam logic [CNT_W-1:0] GAP_CYC = CNT_W'(GAP);

   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;

   // Load restarts the gap, then count down and stop at zero
   assign cnt_next    = gap.load ? GAP_CYC :
                        (cnt_reg != '0) ? cnt_reg - 16'h0001 : cnt_reg;
   assign gap.expired = (cnt_reg == '0);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         cnt_reg <= GAP_CYC;
      else
         cnt_reg <= cnt_next;
   end
endmodule : fug_gap_timer
`default_nettype wire

// ### fug_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module fug_link_model
#(
   parameter int unsigned INIT_CYC = 20
)
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       up_req_i,
   input  wire logic [1:0] go_i,
   output var  logic       chan_up_o,
   output var  logic       flow_ready_o,
   output var  logic       cb_ready_o
);
   logic [7:0] init_reg;

   // Channel comes up a fixed time after the bench asks, and drops at once
   always_ff @(posedge clk_i)
   begin
      if (rst_i || !up_req_i)
      begin
         init_reg  <= 8'h00;
         chan_up_o <= 1'b0;
      end
      else if (init_reg != INIT_CYC[7:0])
         init_reg  <= init_reg + 8'h01;
      else
         chan_up_o <= 1'b1;
   end

   // Ready follows the stall pattern one cycle late, only while the channel is up
   always_ff @(posedge clk_i)
   begin
      flow_ready_o <= !rst_i && chan_up_o && go_i[0];
      cb_ready_o   <= !rst_i && chan_up_o && go_i[1];
   end
endmodule : fug_link_model
`default_nettype wire

// ### test_fug_traffic_generator.sv
`timescale 1ns/1ps
`default_nettype none
module test_fug_traffic_generator;
   import fug_pkg::*;
   localparam int unsigned FGAP = 3;
   localparam int unsigned CGAP = 4;

   logic              clk_i, rst_i, up_req, tx_busy, hold;
   logic [1:0]        go;
   logic              chan_up, flow_ready, cb_ready, flow_valid, cb_valid;
   logic [0:FLOW_W-1] flow_data, fd_q;
   logic [0:CB_W-1]   cb_data, cd_q;
   logic [3:0]        avs_address, avs_byteenable;
   logic              avs_read, avs_write, avs_waitrequest;
   logic [31:0]       avs_writedata, avs_readdata, rdat;
   logic              fv_q, fr_q, cv_q, cr_q, cu_q, last_flag, flow_run, cb_run;
   logic [7:0]        exp_pause;
   logic [63:0]       cb_q[$];
   int                bad_count, compares, nflow, ncb, nflag, fgap, cgap, seed;

   fug_traffic_generator #(.flow_msg_gap_param(FGAP), .ctrl_block_gap_param(CGAP))
      fug_traffic_generator_inst (.clk_i(clk_i), .rst_i(rst_i), .chan_up_i(chan_up),
      .tx_busy_i(tx_busy), .flow_valid_o(flow_valid), .flow_data_o(flow_data),
      .flow_ready_i(flow_ready), .cb_valid_o(cb_valid), .cb_data_o(cb_data),
      .cb_ready_i(cb_ready), .avs_address_i(avs_address), .avs_read_i(avs_read),
      .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
      .avs_byteenable_i(avs_byteenable), .avs_readdata_o(avs_readdata),
      .avs_waitrequest_o(avs_waitrequest));

   fug_link_model fug_link_model_inst (.clk_i(clk_i), .rst_i(rst_i), .up_req_i(up_req),
      .go_i(go), .chan_up_o(chan_up), .flow_ready_o(flow_ready), .cb_ready_o(cb_ready));

   // Clock and random stall pattern for the far side
   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   always @(posedge clk_i)
      go <= hold ? 2'b00 : 2'($random(seed));

   task automatic chk_word(input logic [63:0] got, input logic [63:0] exp);
      begin
         compares++;
         if (got !== exp)
         begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask : chk_word

   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      begin
         chk_word({32'h0, got}, {32'h0, exp});
      end
   endtask : chk_reg

   task automatic chk_gap(input int got, input int exp);
      begin
         chk_word(64'(got), 64'(exp));
      end
   endtask : chk_gap

   // One Avalon access, held until waitrequest is sampled low
   task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] wd,
                      input logic [3:0] be);
      int n;
      begin
         n = 0;
         @(posedge clk_i);
         avs_address    <= a;
         avs_write      <= we;
         avs_read       <= !we;
         avs_writedata  <= wd;
         avs_byteenable <= be;
         do
         begin
            @(posedge clk_i);
            n++;
         end
         while (avs_waitrequest !== 1'b0 && n < 100);
         rdat = avs_readdata;
         if (n >= 100)
            bad_count++;
         avs_read  <= 1'b0;
         avs_write <= 1'b0;
      end
   endtask : bus

   task automatic rreg(input logic [3:0] a, input logic [31:0] e);
      begin
         bus(1'b0, a, 32'h0, 4'hf);
         chk_reg(rdat, e);
      end
   endtask : rreg

   // Stall the far side, then check the acceptance counters
   task automatic count_check();
      begin
         hold <= 1'b1;
         repeat (4) @(posedge clk_i);
         rreg(REG_COUNT, {ncb[15:0], nflow[15:0]});
         hold <= 1'b0;
      end
   endtask : count_check

   task automatic fill_cb();
      begin
         cb_q.delete();
         for (int r = 0; r < 200; r++)
            cb_q.push_back({4'h0, 4'(r % 9), CB_PAYLOAD});
      end
   endtask : fill_cb

   task automatic test_done();
      begin
         $display("compares %0d bad_count %0d", compares, bad_count);
         if (bad_count == 0 && compares > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask : test_done

   // Output watcher: handshake holding, word layout, numbering and gaps
   always @(posedge clk_i)
   begin
      if (!rst_i)
      begin
         if (!chan_up && !cu_q)
            chk_word({62'h0, flow_valid, cb_valid}, 64'h0);
         if (fv_q && !fr_q && cu_q && chan_up)
            chk_word({flow_valid, flow_data}, {1'b1, fd_q});
         if (cv_q && !cr_q && cu_q && chan_up && cb_run)
            chk_word(cb_data, cd_q);
         if (!flow_valid)
            fgap++;
         if (!cb_valid)
            cgap++;
         if (flow_valid && flow_ready && chan_up)
         begin
            chk_word(flow_data, {7'h0, flow_data[7], exp_pause});
            if (last_flag)
               chk_word(flow_data[7], 1'b0);
            if (flow_run && !last_flag && !flow_data[7])
               chk_gap(fgap, FGAP + 1);
            last_flag = flow_data[7];
            nflag += flow_data[7];
            nflow++;
            flow_run = 1'b1;
            fgap = 0;
         end
         if (cb_valid && cb_ready && chan_up)
         begin
            if (cb_q.size() == 0)
               chk_word(cb_data, 64'h0);
            else
               chk_word(cb_data, cb_q.pop_front());
            if (cb_run)
               chk_gap(cgap, CGAP + 1);
            ncb++;
            cb_run = 1'b1;
            cgap = 0;
         end
         if (!chan_up)
         begin
            flow_run = 1'b0;
            cb_run = 1'b0;
         end
      end
      {fv_q, fr_q, cv_q, cr_q, cu_q} <= {flow_valid, flow_ready, cb_valid, cb_ready, chan_up};
      fd_q <= flow_data;
      cd_q <= cb_data;
   end

   // Hang guard
   initial
   begin
      repeat (60000) @(posedge clk_i);
      bad_count++;
      test_done();
   end

   initial
   begin
      seed = 32'h59f3ec96;
      {rst_i, up_req, tx_busy, hold} = 4'b1010;
      {avs_address, avs_read, avs_write, avs_writedata, avs_byteenable} = '0;
      {bad_count, compares, nflow, ncb, nflag, fgap, cgap} = '0;
      {last_flag, flow_run, cb_run} = 3'b000;
      exp_pause = PAUSE_RST;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rreg(REG_CTRL, 32'h0000_0f03);
      rreg(REG_STATUS, 32'h0);
      bus(1'b1, 4'hc, 32'hffff_ffff, 4'hf);
      bus(1'b1, REG_STATUS, 32'hffff_ffff, 4'hf);
      rreg(4'hc, 32'h0);
      rreg(REG_STATUS, 32'h0);
      repeat (100) @(posedge clk_i);
      $display("test 1 done: reset and map");
      bus(1'b1, REG_CTRL, 32'h0000_aa01, 4'h1);
      bus(1'b1, REG_CTRL, 32'h0000_3cff, 4'h2);
      exp_pause = 8'h3c;
      rreg(REG_CTRL, 32'h0000_3c01);
      up_req <= 1'b1;
      repeat (80) @(posedge clk_i);
      rreg(REG_STATUS, 32'h1);
      count_check();
      $display("test 2 done: busy holds off flow messages");
      tx_busy <= 1'b0;
      repeat (1200) @(posedge clk_i);
      chk_word(64'(nflag > 0), 64'h1);
      count_check();
      $display("test 3 done: resume and pause messages");
      fill_cb();
      bus(1'b1, REG_CTRL, 32'h0000_0003, 4'h1);
      repeat (900) @(posedge clk_i);
      count_check();
      $display("test 4 done: control blocks");
      up_req <= 1'b0;
      repeat (40) @(posedge clk_i);
      fill_cb();
      up_req <= 1'b1;
      repeat (600) @(posedge clk_i);
      count_check();
      chk_word(64'(cb_q.size() < 200), 64'h1);
      $display("test 5 done: channel drop and restart");
      test_done();
   end
endmodule : test_fug_traffic_generator
`default_nettype wire
